// ### rtl/sbp_bus.sv
// System bus pin logic of the processor, device side
//
// Operation
// [R1] Byte-lane enables driven in the address clock, marking written or wanted bytes
// [R2] Lower four byte-lane enables sampled in reset as interrupt-controller identity
// [R3] In dual mode upper enable bit four is an input during flush cycles
// [R4] Bus ratio latched in reset, kept until a cold reset of 1 ms
// [R5] Back-off aborts outstanding cycles and floats bus pins next clock
// [R6] After back-off the aborted cycle restarts from its beginning
// [R7] Breakpoint output asserts when a debug address register matches
// [R8] Outputs zero and one shared with perf monitor, perf after reset
// [R9] Burst-ready sampled only in data states; system asserts it on data
// [R10] Duplicate burst-ready treated exactly like burst-ready
// [R11] Bus request output always driven, even while another master owns bus
// [R12] Bus check captures address and control; exception only if enabled
// [R13] System drops stop-clock request before another cycle after bus check
// [R14] Cacheability output marks cacheable reads; inactive read is never cached
// [R15] Role strap low selects primary, high selects secondary
// [R16] Data/code output valid with address strobe
// [R17] Primary drives low while owning the bus, else high
// [R18] 64-bit data, write data driven in data states, read on ready
// [R19] Even parity per byte driven with write data and checked on reads
// [R20] Secondary drives dual-enable low during reset
// [R21] Write buffer not empty after a write holds off later owned-line writes
// [R22] Float error output on unmasked error, never by the secondary
// [R23] Names ending in _N are asserted low
// [R24] Address strobe asserted for one clock per new cycle
`timescale 1ns/1ps
`default_nettype none
`include "sbp_regs.svh"
module sbp_bus #(
  parameter int COLD_RST_CYC = `SBP_COLD_RST_CYC
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Internal event sources
  input  wire logic [3:0]  DEBUG_MATCH,
  input  wire logic [1:0]  PERF_EVENT,
  input  wire logic        FP_ERROR,
  input  wire logic        FLUSH_CYCLE,
  // Straps and system inputs
  input  wire logic [1:0]  BUS_RATIO_SELECT,
  input  wire logic        PROCESSOR_ROLE_STRAP,
  input  wire logic        BACK_OFF_REQUEST_N,
  input  wire logic        BURST_READY_IN_N,
  input  wire logic        BURST_READY_DUP_N,
  input  wire logic        BUS_CHECK_IN_N,
  input  wire logic        EXTERNAL_CACHE_ENABLE_IN_N,
  input  wire logic        EXT_WRITE_BUFFER_EMPTY_N,
  // Byte-lane enables, two-way
  input  wire logic [7:0]  BYTE_EN_IN_N,
  output logic      [7:0]  BYTE_EN_OUT_N,
  output logic      [7:0]  BYTE_EN_OE,
  // Address and cycle definition
  output logic      [28:0] ADDR_OUT,
  output logic             ADDR_OE,
  output logic             ADDRESS_STROBE_OUT_N,
  output logic             DATA_CODE_OUT,
  output logic             WRITE_READ_OUT,
  output logic             CACHE_OUT_N,
  output logic             DUAL_PRIMARY_OUT_N,
  output logic             INTERNAL_BUS_REQUEST_OUT,
  // Data and parity, two-way
  input  wire logic [63:0] DATA_IN,
  input  wire logic [7:0]  PARITY_IN,
  output logic      [63:0] DATA_OUT,
  output logic      [7:0]  PARITY_OUT,
  output logic             DATA_OE,
  // Dual enable, output and output enable
  output logic             DUAL_ENABLE_OUT_N,
  output logic             DUAL_ENABLE_OE,
  // Debug, error and strap outputs
  output logic      [1:0]  BREAKPOINT_MATCH_OUT,
  output logic      [1:0]  PERF_OR_BREAKPOINT_OUT,
  output logic             FLOAT_ERROR_OUT_N,
  output logic             MACHINE_CHECK_OUT,
  output logic      [1:0]  BUS_RATIO_OUT,
  output logic      [3:0]  INTC_ID_OUT
);

  function automatic logic [7:0] even_par(input logic [63:0] d);
    for (int i = 0; i < 8; i++)
      even_par[i] = ^d[i*8 +: 8];
  endfunction : even_par

  sbp_pkg::sbp_state_t state_r;
  sbp_pkg::sbp_req_t   req_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  debug_r;
  logic [63:0] wdata_r;
  logic [63:0] rdata_r;
  logic        busy_r;
  logic        done_r;
  logic        par_err_r;
  logic        mc_pend_r;
  logic [28:0] mca_addr_r;
  logic [10:0] mca_ctl_r;
  logic        wb_hold_r;
  logic        role_r;
  logic        rst_d_r;
  logic [31:0] cold_cnt_r;
  logic        cold_r;
  logic        back_off_request_cnt_r;
  logic        ready;
  logic        back_off_request;
  logic        wr_en;
  logic        rd_en;
  logic        go;
  logic        owned_wr;
  logic [31:0] rdata_nxt;

  assign ready = !BURST_READY_IN_N || !BURST_READY_DUP_N; // [R10]
  assign back_off_request  = !BACK_OFF_REQUEST_N; // [R23]
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign owned_wr = req_r.write && req_r.cacheable;
  assign go    = busy_r && !back_off_request && !(owned_wr && wb_hold_r); // [R21]

  // Register writes
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_r  <= `SBP_CTRL_RST;
      debug_r <= `SBP_DEBUG_RST; // [R8]
      req_r   <= '0;
      wdata_r <= '0;
    end
    else if (wr_en)
    begin
      case (PADDR)
        `SBP_CTRL_OFF:     ctrl_r <= PWDATA[7:0];
        `SBP_DEBUG_OFF:    debug_r <= PWDATA[7:0];
        `SBP_REQ_OFF:      req_r <= {PWDATA[31:21], 8'h00, PWDATA[20:0]};
        `SBP_WDATA_LO_OFF: wdata_r[31:0] <= PWDATA;
        `SBP_WDATA_HI_OFF: wdata_r[63:32] <= PWDATA;
        default:           ctrl_r <= ctrl_r;
      endcase
    end
  end

  // APB answer, one wait-free access phase
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (PADDR)
      `SBP_CTRL_OFF:     rdata_nxt = {24'h00_0000, ctrl_r};
      `SBP_DEBUG_OFF:    rdata_nxt = {24'h00_0000, debug_r};
      `SBP_REQ_OFF:      rdata_nxt = {req_r.write, req_r.data_cyc,
                                      req_r.cacheable, req_r.byte_en,
                                      req_r.addr[20:0]};
      `SBP_WDATA_LO_OFF: rdata_nxt = wdata_r[31:0];
      `SBP_WDATA_HI_OFF: rdata_nxt = wdata_r[63:32];
      `SBP_STATUS_OFF:   rdata_nxt = {26'h000_0000, role_r, wb_hold_r,
                                      mc_pend_r, par_err_r, done_r, busy_r};
      `SBP_RDATA_LO_OFF: rdata_nxt = rdata_r[31:0];
      `SBP_RDATA_HI_OFF: rdata_nxt = rdata_r[63:32];
      `SBP_MCA_OFF:      rdata_nxt = {mca_ctl_r[2:0], mca_addr_r};
      `SBP_STRAP_OFF:    rdata_nxt = {26'h000_0000, INTC_ID_OUT, BUS_RATIO_OUT};
      default:           rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && (PADDR > `SBP_STRAP_OFF);
      if (rd_en)
        PRDATA <= rdata_nxt;
    end
  end

  // Reset straps and cold-reset measurement
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rst_d_r    <= 1'b1;
      cold_cnt_r <= 32'h0000_0000;
      cold_r     <= 1'b1;
    end
    else
    begin
      rst_d_r <= 1'b0;
      if (rst_d_r)
        cold_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      INTC_ID_OUT <= ~BYTE_EN_IN_N[3:0]; // [R2]
      role_r      <= PROCESSOR_ROLE_STRAP; // [R15]
    end
  end

  // Bus ratio kept across warm resets
  logic [31:0] rst_len_r;
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      // Unknown count at power-up falls to the latch branch
      if (rst_len_r < 32'(COLD_RST_CYC - 1))
        rst_len_r <= rst_len_r + 32'h1;
      else
      begin
        rst_len_r     <= 32'(COLD_RST_CYC - 1);
        BUS_RATIO_OUT <= BUS_RATIO_SELECT; // [R4]
      end
    end
    else
      rst_len_r <= 32'h0000_0000;
  end

  // Bus cycle sequencer
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      state_r <= sbp_pkg::ST_IDLE;
    else
    begin
      case (state_r)
        sbp_pkg::ST_IDLE:
          if (back_off_request)
            state_r <= sbp_pkg::ST_BACK_OFF_REQUEST; // [R5]
          else if (go)
            state_r <= sbp_pkg::ST_ADDR;
        sbp_pkg::ST_ADDR:
          state_r <= back_off_request ? sbp_pkg::ST_BACK_OFF_REQUEST : sbp_pkg::ST_DATA;
        sbp_pkg::ST_DATA:
          if (back_off_request)
            state_r <= sbp_pkg::ST_BACK_OFF_REQUEST; // [R5]
          else if (ready)
            state_r <= sbp_pkg::ST_IDLE; // [R9]
        sbp_pkg::ST_BACK_OFF_REQUEST:
          if (!back_off_request)
            state_r <= sbp_pkg::ST_IDLE; // [R6]
        default:
          state_r <= sbp_pkg::ST_IDLE;
      endcase
    end
  end

  // Request, completion and read data
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      rdata_r   <= '0;
      par_err_r <= 1'b0;
    end
    else
    begin
      if (state_r == sbp_pkg::ST_DATA && ready && !back_off_request)
      begin
        busy_r <= 1'b0; // [R9]
        done_r <= 1'b1;
        if (!req_r.write)
        begin
          rdata_r   <= DATA_IN; // [R18]
          par_err_r <= par_err_r || (PARITY_IN != even_par(DATA_IN)); // [R19]
        end
      end
      else if (wr_en && PADDR == `SBP_REQ_OFF)
      begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
      end
      if (wr_en && PADDR == `SBP_STATUS_OFF && PWDATA[2]
          && !(state_r == sbp_pkg::ST_DATA && ready && !req_r.write))
        par_err_r <= 1'b0;
    end
  end

  // Bus check capture and machine check
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      mc_pend_r         <= 1'b0;
      mca_addr_r        <= '0;
      mca_ctl_r         <= '0;
      MACHINE_CHECK_OUT <= 1'b0;
    end
    else
    begin
      if (!BUS_CHECK_IN_N && state_r == sbp_pkg::ST_DATA)
      begin
        mca_addr_r <= req_r.addr; // [R12]
        mca_ctl_r  <= {req_r.byte_en, req_r.cacheable,
                       req_r.data_cyc, req_r.write};
        mc_pend_r  <= 1'b1;
      end
      else if (wr_en && PADDR == `SBP_STATUS_OFF && PWDATA[3])
        mc_pend_r <= 1'b0;
      MACHINE_CHECK_OUT <= !BUS_CHECK_IN_N && state_r == sbp_pkg::ST_DATA
                           && ctrl_r[`SBP_CTRL_MCE_BIT]; // [R12]
    end
  end

  // Write-buffer hold-off
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      wb_hold_r <= 1'b0;
    else if (state_r == sbp_pkg::ST_DATA && ready && req_r.write
             && EXT_WRITE_BUFFER_EMPTY_N)
      wb_hold_r <= 1'b1; // [R21]
    else if (!EXT_WRITE_BUFFER_EMPTY_N)
      wb_hold_r <= 1'b0;
  end

  // Bus pins
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ADDRESS_STROBE_OUT_N     <= 1'b1;
      ADDR_OUT                 <= '0;
      ADDR_OE                  <= 1'b0;
      BYTE_EN_OUT_N            <= 8'hFF;
      BYTE_EN_OE               <= 8'h00;
      DATA_CODE_OUT            <= 1'b0;
      WRITE_READ_OUT           <= 1'b0;
      CACHE_OUT_N              <= 1'b1;
      DUAL_PRIMARY_OUT_N       <= 1'b1;
      DATA_OUT                 <= '0;
      PARITY_OUT               <= 8'h00;
      DATA_OE                  <= 1'b0;
      INTERNAL_BUS_REQUEST_OUT <= 1'b0;
    end
    else
    begin
      INTERNAL_BUS_REQUEST_OUT <= busy_r; // [R11]
      ADDRESS_STROBE_OUT_N <= !(state_r == sbp_pkg::ST_IDLE && go); // [R24]
      if (state_r == sbp_pkg::ST_IDLE && go)
      begin
        ADDR_OUT      <= req_r.addr;
        BYTE_EN_OUT_N <= ~req_r.byte_en; // [R1]
        DATA_CODE_OUT <= req_r.data_cyc; // [R16]
        WRITE_READ_OUT <= req_r.write;
        CACHE_OUT_N   <= !req_r.cacheable; // [R14]
      end
      ADDR_OE    <= busy_r && !back_off_request; // [R5]
      BYTE_EN_OE <= (busy_r && !back_off_request) ? ((ctrl_r[`SBP_CTRL_DUAL_BIT]
                    && FLUSH_CYCLE) ? 8'hEF : 8'hFF) : 8'h00; // [R3]
      DUAL_PRIMARY_OUT_N <= !(!role_r && busy_r && !back_off_request); // [R17]
      DATA_OE    <= !back_off_request && req_r.write
                    && (state_r == sbp_pkg::ST_ADDR
                        || state_r == sbp_pkg::ST_DATA); // [R18]
      DATA_OUT   <= wdata_r;
      PARITY_OUT <= even_par(wdata_r); // [R19]
    end
  end

  // Debug, perf and float error outputs
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      BREAKPOINT_MATCH_OUT   <= 2'b00;
      PERF_OR_BREAKPOINT_OUT <= 2'b00;
      FLOAT_ERROR_OUT_N      <= 1'b1;
    end
    else
    begin
      BREAKPOINT_MATCH_OUT <= DEBUG_MATCH[3:2]; // [R7]
      for (int i = 0; i < 2; i++)
        PERF_OR_BREAKPOINT_OUT[i] <= debug_r[i] ? DEBUG_MATCH[i]
                                                : PERF_EVENT[i]; // [R8]
      FLOAT_ERROR_OUT_N <= !(FP_ERROR && !role_r); // [R22]
    end
  end

  // Dual-enable driven by the secondary during reset
  always_ff @(posedge REF_CLK)
  begin
    DUAL_ENABLE_OUT_N <= !(RST && PROCESSOR_ROLE_STRAP); // [R20]
    DUAL_ENABLE_OE    <= RST && PROCESSOR_ROLE_STRAP; // [R20]
  end

  chk_back_off_request_float: assert property (@(posedge REF_CLK) disable iff (RST)
    back_off_request |=> !ADDR_OE && !DATA_OE) // [R5]
    else $error("pins not floated after back-off");
  chk_strobe_one: assert property (@(posedge REF_CLK) disable iff (RST)
    !ADDRESS_STROBE_OUT_N |=> ADDRESS_STROBE_OUT_N) // [R24]
    else $error("address strobe longer than one clock");
  chk_internal_bus_request_out_drive: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(busy_r) |=> INTERNAL_BUS_REQUEST_OUT) // [R11]
    else $error("bus request not shown");
  chk_float_error_out_second: assert property (@(posedge REF_CLK) disable iff (RST)
    role_r |-> FLOAT_ERROR_OUT_N) // [R22]
    else $error("secondary drove float error");
  chk_mce_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    MACHINE_CHECK_OUT |-> ctrl_r[`SBP_CTRL_MCE_BIT] && mc_pend_r) // [R12]
    else $error("machine check without enable");
  chk_par_write: assert property (@(posedge REF_CLK) disable iff (RST)
    DATA_OE |-> PARITY_OUT == even_par(DATA_OUT)) // [R19]
    else $error("write parity wrong");
  chk_be_strobe: assert property (@(posedge REF_CLK) disable iff (RST)
    !ADDRESS_STROBE_OUT_N |-> BYTE_EN_OUT_N == ~req_r.byte_en) // [R1]
    else $error("byte enables not with strobe");
  chk_wb_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    wb_hold_r && owned_wr && state_r == sbp_pkg::ST_IDLE
    |=> ADDRESS_STROBE_OUT_N) // [R21]
    else $error("owned write issued while buffer busy");

endmodule : sbp_bus
`default_nettype wire

// ### rtl/sbp_regs.svh
// Register offsets, fields, reset values and timing counts
`ifndef SBP_REGS_SVH
`define SBP_REGS_SVH
`define SBP_CTRL_OFF      12'h000
`define SBP_DEBUG_OFF     12'h004
`define SBP_REQ_OFF       12'h008
`define SBP_WDATA_LO_OFF  12'h00C
`define SBP_WDATA_HI_OFF  12'h010
`define SBP_STATUS_OFF    12'h014
`define SBP_RDATA_LO_OFF  12'h018
`define SBP_RDATA_HI_OFF  12'h01C
`define SBP_MCA_OFF       12'h020
`define SBP_STRAP_OFF     12'h024
`define SBP_EVENT_OFF     12'h028
`define SBP_CTRL_MCE_BIT  0
`define SBP_CTRL_DUAL_BIT 1
`define SBP_CTRL_RST      8'h00
`define SBP_DEBUG_RST     8'h00
`define SBP_CLK_MHZ       20
`define SBP_COLD_RST_US   1000
`define SBP_COLD_RST_CYC  (`SBP_COLD_RST_US * `SBP_CLK_MHZ)
`endif

// ### rtl/sbp_pkg.sv
// Types for the system bus pin logic
package sbp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_BACK_OFF_REQUEST = 2'b11
  } sbp_state_t;
  typedef struct packed {
    logic        write;
    logic        data_cyc;
    logic        cacheable;
    logic [7:0]  byte_en;
    logic [28:0] addr;
  } sbp_req_t;
endpackage : sbp_pkg

// ### testbench/sbp_chipset_model.sv
// Chipset model that answers the processor's bus cycles
`timescale 1ns/1ps
`default_nettype none
module sbp_chipset_model #(
  parameter logic [63:0] RDATA = 64'h0123_4567_89AB_CDEF
) (
  // Clock, reset and test controls
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  dly,
  input  wire logic        use_dup,
  input  wire logic        bad_par,
  input  wire logic        chk_err,
  // Processor side
  input  wire logic        strobe_n,
  input  wire logic        back_off_request_n,
  input  wire logic [40:0] cyc,
  input  wire logic [71:0] dpin,
  output logic             rdy_n,
  output logic             rdy_dup_n,
  output logic             bus_check_in_n,
  output logic      [71:0] dout,
  // Observations
  output int               n_strobe,
  output logic      [40:0] cap_cyc,
  output logic      [71:0] cap_wd
);
  logic       act;
  logic [3:0] cnt;
  logic [7:0] par;

  // Even parity per byte, byte zero spoiled on request
  always_comb
    for (int i = 0; i < 8; i++)
      par[i] = ^RDATA[8*i +: 8] ^ (i == 0 && bad_par);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdy_n     <= 1'b1;
      rdy_dup_n <= 1'b1;
      bus_check_in_n  <= 1'b1;
      dout      <= 72'h0;
      act       <= 1'b0;
      cnt       <= 4'h0;
      n_strobe  <= 0;
      cap_cyc   <= 41'h0;
      cap_wd    <= 72'h0;
    end
    else
    begin
      rdy_n     <= 1'b1;
      rdy_dup_n <= 1'b1;
      bus_check_in_n  <= 1'b1;
      dout      <= ~dout;
      if (!rdy_n || !rdy_dup_n)
        cap_wd <= dpin;
      if (!back_off_request_n)
        act <= 1'b0;
      else if (!strobe_n)
      begin
        act      <= 1'b1;
        cnt      <= dly;
        n_strobe <= n_strobe + 1;
        cap_cyc  <= cyc;
      end
      else if (act && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (act)
      begin
        act       <= 1'b0;
        rdy_n     <= use_dup;
        rdy_dup_n <= !use_dup;
        bus_check_in_n  <= !chk_err;
        dout      <= {par, RDATA};
      end
    end
  end
endmodule : sbp_chipset_model
`default_nettype wire

// ### testbench/sbp_bus_tb_top.sv
// Self-checking testbench for the system bus pin logic
`timescale 1ns/1ps
`default_nettype none
`include "sbp_regs.svh"
module sbp_bus_tb_top;
  // Design and model connections
  logic        clk, rst, psel, pen, pwr, pready, pslverr, last_err;
  logic        fpe, back_off_request_n, ext_write_buffer_empty_n, rdy_n, rdyd_n, bchk_n, d_oe, a_oe;
  logic        strb_n, dc, wr, cch_n, dp_n, internal_bus_request_out, fe_n, de_oe, mc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  dbg, id, dly;
  logic [1:0]  perf, ratio, ratio_o, bp, pb;
  logic [7:0]  be_drv_n, be_n, be_oe, be_pin, par_o;
  logic [28:0] addr;
  logic [63:0] dat_o;
  logic [71:0] mdl_d, pin_d, cap_wd;
  logic [40:0] cap_cyc;
  logic        use_dup, bad_par, chk_err;
  int          n_strobe, n0, n_fail, total_checks, n_mc;

  // Machine check is a one-clock pulse; count it
  always @(posedge clk)
    n_mc <= n_mc + ((mc === 1'b1) ? 1 : 0);

  // Two-way pins: the driving party sets the level
  assign be_pin = (be_oe & be_n) | (~be_oe & be_drv_n);
  assign pin_d  = d_oe ? {par_o, dat_o} : mdl_d;

  sbp_bus #(.COLD_RST_CYC(2)) u_sbp_bus (
    .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DEBUG_MATCH(dbg), .PERF_EVENT(perf), .FP_ERROR(fpe),
    .FLUSH_CYCLE(1'b0), .BUS_RATIO_SELECT(ratio),
    .PROCESSOR_ROLE_STRAP(1'b0), .BACK_OFF_REQUEST_N(back_off_request_n),
    .BURST_READY_IN_N(rdy_n), .BURST_READY_DUP_N(rdyd_n),
    .BUS_CHECK_IN_N(bchk_n), .EXTERNAL_CACHE_ENABLE_IN_N(1'b0),
    .EXT_WRITE_BUFFER_EMPTY_N(ext_write_buffer_empty_n), .BYTE_EN_IN_N(be_pin),
    .BYTE_EN_OUT_N(be_n), .BYTE_EN_OE(be_oe), .ADDR_OUT(addr),
    .ADDR_OE(a_oe), .ADDRESS_STROBE_OUT_N(strb_n), .DATA_CODE_OUT(dc),
    .WRITE_READ_OUT(wr), .CACHE_OUT_N(cch_n), .DUAL_PRIMARY_OUT_N(dp_n),
    .INTERNAL_BUS_REQUEST_OUT(internal_bus_request_out), .DATA_IN(pin_d[63:0]),
    .PARITY_IN(pin_d[71:64]), .DATA_OUT(dat_o), .PARITY_OUT(par_o),
    .DATA_OE(d_oe), .DUAL_ENABLE_OUT_N(), .DUAL_ENABLE_OE(de_oe),
    .BREAKPOINT_MATCH_OUT(bp), .PERF_OR_BREAKPOINT_OUT(pb),
    .FLOAT_ERROR_OUT_N(fe_n), .MACHINE_CHECK_OUT(mc),
    .BUS_RATIO_OUT(ratio_o), .INTC_ID_OUT(id));

  sbp_chipset_model u_sbp_chipset_model (
    .clk(clk), .rst(rst), .dly(dly), .use_dup(use_dup), .bad_par(bad_par),
    .chk_err(chk_err), .strobe_n(strb_n), .back_off_request_n(back_off_request_n),
    .cyc({be_n, wr, dc, cch_n, dp_n, addr}), .dpin(pin_d), .rdy_n(rdy_n),
    .rdy_dup_n(rdyd_n), .bus_check_in_n(bchk_n), .dout(mdl_d),
    .n_strobe(n_strobe), .cap_cyc(cap_cyc), .cap_wd(cap_wd));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_up;
    n_fail++;
    $display("[ERR] %0t: wait ran out", $time);
    tally_and_finish();
  endtask : give_up

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    pen    <= 1'b0;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    pen     <= 1'b0;
    if (i >= 20)
      give_up();
  endtask : apb

  task automatic wait_idle;
    int i;
    for (i = 0; i < 40; i++)
    begin
      apb(1'b0, `SBP_STATUS_OFF, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
    if (i >= 40)
      give_up();
  endtask : wait_idle

  initial
  begin
    {psel, pen, pwr, fpe, ext_write_buffer_empty_n, use_dup, bad_par, chk_err} = 8'h00;
    {rst, back_off_request_n} = 2'h3;
    {paddr, pwdata} = 44'h0;
    {dbg, perf, ratio, dly} = 12'h5A0;
    n_fail = 0;
    n_mc = 0;
    total_checks = 0;
    be_drv_n = 8'hF6;
    repeat (2) @(posedge clk);
    rst      <= 1'b0;
    ratio    <= 2'h1;
    be_drv_n <= 8'hFF;
    repeat (2) @(posedge clk);
    chk(ratio_o, 2'h2);
    chk(id, 4'h9);
    chk({pb, bp}, 4'h9);
    chk({strb_n, de_oe, a_oe, internal_bus_request_out, fe_n}, 5'h11);
    apb(1'b0, `SBP_DEBUG_OFF, 32'h0);
    chk(rd, {24'h0, `SBP_DEBUG_RST});
    apb(1'b0, 12'h030, 32'h0);
    chk({last_err, rd}, {1'b1, 32'h0});
    apb(1'b0, `SBP_STATUS_OFF, 32'h0);
    chk(rd[5], 1'b0);
    apb(1'b1, `SBP_DEBUG_OFF, 32'h3);
    fpe <= 1'b1;
    repeat (2) @(posedge clk);
    chk({pb, fe_n}, 3'h2);
    // Cacheable data read, prompt answer
    apb(1'b1, `SBP_REQ_OFF, {3'h3, 8'hFF, 21'h000040});
    wait_idle();
    chk(cap_cyc, {8'h00, 4'h4, 29'h40});
    apb(1'b0, `SBP_RDATA_LO_OFF, 32'h0);
    chk(rd, 32'h89AB_CDEF);
    apb(1'b0, `SBP_RDATA_HI_OFF, 32'h0);
    chk(rd, 32'h0123_4567);
    // Write with slow answer on the duplicate ready, buffer not empty
    dly     <= 4'h3;
    use_dup <= 1'b1;
    ext_write_buffer_empty_n  <= 1'b1;
    apb(1'b1, `SBP_WDATA_LO_OFF, 32'hA5A5_0F0F);
    apb(1'b1, `SBP_WDATA_HI_OFF, 32'h1122_3380);
    apb(1'b1, `SBP_REQ_OFF, {3'h6, 8'h0F, 21'h1FFFF8});
    wait_idle();
    chk(cap_wd, 72'h10_1122_3380_A5A5_0F0F);
    chk(cap_cyc, {8'hF0, 4'hE, 29'h1FFFF8});
    apb(1'b0, `SBP_STATUS_OFF, 32'h0);
    chk(rd[4], 1'b1);
    ext_write_buffer_empty_n <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, `SBP_STATUS_OFF, 32'h0);
    chk(rd[4], 1'b0);
    // Code read returning bad parity
    {dly, use_dup, bad_par} <= 6'h01;
    apb(1'b1, `SBP_REQ_OFF, {3'h1, 8'hFF, 21'h000080});
    wait_idle();
    chk(cap_cyc[32:29], 4'h0);
    apb(1'b0, `SBP_STATUS_OFF, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, `SBP_STATUS_OFF, 32'h4);
    apb(1'b0, `SBP_STATUS_OFF, 32'h0);
    chk(rd[2], 1'b0);
    // Bus check, first without then with the enable
    {bad_par, chk_err} <= 2'h1;
    apb(1'b1, `SBP_REQ_OFF, {3'h2, 8'hFF, 21'h000100});
    wait_idle();
    chk(n_mc, 0);
    apb(1'b0, `SBP_MCA_OFF, 32'h0);
    chk(rd[20:0], 21'h100);
    apb(1'b1, `SBP_CTRL_OFF, 32'h1);
    apb(1'b1, `SBP_REQ_OFF, {3'h2, 8'hFF, 21'h000100});
    wait_idle();
    chk(n_mc, 1);
    // Back-off in mid-cycle, then the whole cycle again
    chk_err <= 1'b0;
    dly     <= 4'h4;
    n0 = n_strobe;
    apb(1'b1, `SBP_REQ_OFF, {3'h3, 8'h3C, 21'h000200});
    for (int i = 0; i < 20 && strb_n !== 1'b0; i++)
      @(negedge clk);
    @(posedge clk);
    back_off_request_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({a_oe, d_oe, be_oe, dp_n, internal_bus_request_out}, 12'h003);
    repeat (3) @(posedge clk);
    back_off_request_n <= 1'b1;
    wait_idle();
    chk(n_strobe - n0, 2);
    chk({cap_cyc[40:33], cap_cyc[28:0]}, {8'hC3, 29'h200});
    tally_and_finish();
  end
endmodule : sbp_bus_tb_top
`default_nettype wire
